// [lcsr_pkg.sv]
// lcsr_pkg: word layout, command codes, reset values and timing counts
// for the led driver configuration and status register bank.
// assumes a 100 MHz system clock and 288-bit host frames.
package lcsr_pkg;

	// ==========================================================
	// word geometry and offsets
	localparam int          WORD_W          = 288;
	localparam int          CFG_W           = 205;
	localparam int          CH_N            = 16;
	localparam int          DC_W            = 7;
	localparam int          DC_STEP         = 21;
	localparam int          DC_B_SHIFT      = 14;
	localparam logic [1:0]  OFS_CONFIG      = 2'h1;
	localparam logic [1:0]  OFS_STATUS      = 2'h2;

	// ==========================================================
	// command field and codes
	localparam int          CMD_LO          = 276;
	localparam int          CMD_W           = 12;
	localparam logic [11:0] CMD_GLOBAL_RST  = 12'h25C;
	localparam logic [11:0] CMD_SELFTEST    = 12'h535;
	localparam logic [11:0] CMD_NEIGH_CHECK = 12'h53A;
	localparam logic [11:0] CMD_NEG_TOGGLE  = 12'h55A;
	localparam logic [11:0] CMD_STATUS_READ = 12'h5A3;
	localparam logic [11:0] CMD_CONFIG_READ = 12'h5AC;
	localparam logic [11:0] CMD_GRAY_READ   = 12'h5AF;
	localparam logic [11:0] CMD_ERROR_CLEAR = 12'hA53;

	// ==========================================================
	// configuration field positions
	localparam int          ERR_MASK_BIT    = 204;
	localparam int          SLEW_BIT        = 203;
	localparam int          OPEN_THR_BIT    = 202;
	localparam int          SHORT_THR_BIT   = 201;
	localparam int          NTEST_CUR_BIT   = 200;
	localparam int          NTEST_DUR_BIT   = 199;
	localparam int          GRAY_W_LO       = 197;
	localparam int          TIMING_RST_BIT  = 196;
	localparam int          AUTO_REP_BIT    = 195;
	localparam int          B_RANGE_BIT     = 194;
	localparam int          R_RANGE_BIT     = 192;
	localparam int          B_BRIGHT_LO     = 184;
	localparam int          R_BRIGHT_LO     = 168;
	localparam logic        ERR_MASK_RST    = 1'h1;

	// ==========================================================
	// status field positions
	localparam int          ST_OPEN2_B      = 280;
	localparam int          ST_OPEN2_R      = 264;
	localparam int          ST_OPEN1_B      = 256;
	localparam int          ST_OPEN1_R      = 240;
	localparam int          ST_NEIGH_B      = 232;
	localparam int          ST_UNUSED       = 224;
	localparam int          ST_NEIGH_R      = 216;
	localparam int          ST_OVERTEMP     = 215;
	localparam int          ST_PREWARN      = 214;
	localparam int          ST_NTEST_LO     = 211;
	localparam int          ST_REF_SHORT    = 210;
	localparam int          ST_REF_OPEN     = 209;
	localparam int          ST_SELF_LO      = 206;
	localparam int          ST_NEGATE_BIT_ONE         = 205;
	localparam int          ST_NEGATE_BIT_ZERO         = 204;
	localparam int          ST_SHORT2_B     = 184;
	localparam int          ST_SHORT2_R     = 168;
	localparam int          ST_SHORT1_B     = 160;
	localparam int          ST_SHORT1_R     = 144;
	localparam logic [2:0]  RESULT_PASS     = 3'h3;
	localparam logic [2:0]  RESULT_FAIL     = 3'h6;
	localparam logic [2:0]  RESULT_NONE     = 3'h0;

	// ==========================================================
	// grayscale counter widths
	localparam logic [3:0]  GRAY_BITS_12    = 4'hC;
	localparam logic [3:0]  GRAY_BITS_10    = 4'hA;
	localparam logic [3:0]  GRAY_BITS_8     = 4'h8;

	// ==========================================================
	// timing
	localparam int          CLK_PERIOD_NS   = 10;
	localparam int          SLEW_FAST_NS    = 100;
	localparam int          SLEW_SLOW_NS    = 200;
	localparam int          NTEST_SHORT_US  = 10;
	localparam int          NTEST_LONG_US   = 20;
	localparam int          SLEW_FAST_CYC   = SLEW_FAST_NS / CLK_PERIOD_NS;
	localparam int          SLEW_SLOW_CYC   = SLEW_SLOW_NS / CLK_PERIOD_NS;
	localparam int          NTEST_SHORT_CYC = NTEST_SHORT_US * 1000 / CLK_PERIOD_NS;
	localparam int          NTEST_LONG_CYC  = NTEST_LONG_US * 1000 / CLK_PERIOD_NS;

endpackage : lcsr_pkg

// [lcsr_regs.sv]
// lcsr_regs: configuration word and read-only status word of the led sink driver.
// assumes the serial shifter delivers whole 288-bit frames with a one-cycle strobe
// and that the detector front end delivers fault events as one-cycle pulses.
`timescale 1ns/1ns

module lcsr_regs (
	// clock and reset
	input  wire logic                          clk_in,
	input  wire logic                          rst_n_in,
	// host frame from the serial shifter
	input  wire logic                          frame_valid_in,
	input  wire logic [lcsr_pkg::WORD_W-1:0]   frame_word_in,
	// read-back frame toward the shift-out register
	output logic                               read_valid_out,
	output logic [1:0]                         read_source_out,
	output logic [lcsr_pkg::WORD_W-1:0]        read_word_out,
	// decoded configuration
	output logic                               led_error_mask_out,
	output logic                               slew_slow_out,
	output logic [4:0]                         edge_cycles_out,
	output logic                               open_threshold_select_out,
	output logic                               short_threshold_select_out,
	output logic                               neighbour_test_current_out,
	output logic [10:0]                        neighbour_test_cycles_out,
	output logic [3:0]                         gray_counter_bits_out,
	output logic                               timing_reset_en_out,
	output logic                               auto_repeat_en_out,
	output logic                               b_group_correction_range_out,
	output logic                               r_group_correction_range_out,
	output logic [7:0]                         b_group_brightness_out,
	output logic [7:0]                         r_group_brightness_out,
	output logic [lcsr_pkg::CH_N*7-1:0]        channel_dot_correction_out,
	// detector events, bit n = r channel n, bit 8+n = b channel n
	input  wire logic [lcsr_pkg::CH_N-1:0]     open_first_in,
	input  wire logic [lcsr_pkg::CH_N-1:0]     open_second_in,
	input  wire logic [lcsr_pkg::CH_N-1:0]     short_first_in,
	input  wire logic [lcsr_pkg::CH_N-1:0]     short_second_in,
	input  wire logic [lcsr_pkg::CH_N-1:0]     neighbour_short_in,
	input  wire logic [7:0]                    unused_pin_neighbour_in,
	input  wire logic                          overtemp_in,
	input  wire logic                          prewarn_in,
	input  wire logic                          ref_short_in,
	input  wire logic                          ref_open_in,
	input  wire logic                          neighbour_test_done_in,
	input  wire logic                          neighbour_test_pass_in,
	input  wire logic                          selftest_done_in,
	input  wire logic                          selftest_pass_in,
	input  wire logic                          negate_bit_one_in,
	input  wire logic                          negate_bit_zero_in
);
	import lcsr_pkg::*;

	// ==========================================================
	// command decode
	logic [CMD_W-1:0] cmd;
	logic             is_known_cmd;
	logic             do_status_read;
	logic             do_config_read;
	logic             do_clear;
	logic             do_store;

	// command field sits at the top of every frame
	assign cmd            = frame_word_in[CMD_LO +: CMD_W];
	assign do_status_read = frame_valid_in && (cmd == CMD_STATUS_READ);
	assign do_config_read = frame_valid_in && (cmd == CMD_CONFIG_READ);
	assign do_clear       = frame_valid_in && (cmd == CMD_ERROR_CLEAR);

	// any listed command is an action, a frame with any other command code loads configuration
	always_comb begin
		is_known_cmd = 1'b0;
		if (cmd == CMD_GLOBAL_RST || cmd == CMD_SELFTEST || cmd == CMD_NEIGH_CHECK) begin
			is_known_cmd = 1'b1;
		end else if (cmd == CMD_NEG_TOGGLE || cmd == CMD_GRAY_READ) begin
			is_known_cmd = 1'b1;
		end else if (cmd == CMD_STATUS_READ || cmd == CMD_CONFIG_READ || cmd == CMD_ERROR_CLEAR) begin
			is_known_cmd = 1'b1;
		end
	end
	assign do_store = frame_valid_in && !is_known_cmd;

	// ==========================================================
	// configuration storage
	logic [CFG_W-1:0] cfg_q;
	logic [CFG_W-1:0] cfg_d;

	// reserved bits are kept as written, host keeps them zero
	assign cfg_d = do_store ? frame_word_in[CFG_W-1:0] : cfg_q;

	// configuration word, error mask resets set
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			cfg_q               <= '0;
			cfg_q[ERR_MASK_BIT] <= ERR_MASK_RST;
		end else begin
			cfg_q <= cfg_d;
		end
	end

	// ==========================================================
	// decoded single-bit controls, registered alongside the word
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			led_error_mask_out           <= ERR_MASK_RST;
			slew_slow_out                <= 1'b0;
			edge_cycles_out              <= 5'(SLEW_FAST_CYC);
			open_threshold_select_out    <= 1'b0;
			short_threshold_select_out   <= 1'b0;
			neighbour_test_current_out   <= 1'b0;
			neighbour_test_cycles_out    <= 11'(NTEST_SHORT_CYC);
			timing_reset_en_out          <= 1'b0;
			auto_repeat_en_out           <= 1'b0;
			b_group_correction_range_out <= 1'b0;
			r_group_correction_range_out <= 1'b0;
		end else begin
			led_error_mask_out           <= cfg_d[ERR_MASK_BIT];
			slew_slow_out                <= cfg_d[SLEW_BIT];
			edge_cycles_out              <= cfg_d[SLEW_BIT] ? 5'(SLEW_SLOW_CYC) : 5'(SLEW_FAST_CYC);
			open_threshold_select_out    <= cfg_d[OPEN_THR_BIT];
			short_threshold_select_out   <= cfg_d[SHORT_THR_BIT];
			neighbour_test_current_out   <= cfg_d[NTEST_CUR_BIT];
			neighbour_test_cycles_out    <= cfg_d[NTEST_DUR_BIT] ? 11'(NTEST_LONG_CYC)
			                                                     : 11'(NTEST_SHORT_CYC);
			timing_reset_en_out          <= cfg_d[TIMING_RST_BIT];
			auto_repeat_en_out           <= cfg_d[AUTO_REP_BIT];
			b_group_correction_range_out <= cfg_d[B_RANGE_BIT];
			r_group_correction_range_out <= cfg_d[R_RANGE_BIT];
		end
	end

	// grayscale counter width, codes 0 and 1 both mean twelve bits
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			gray_counter_bits_out <= GRAY_BITS_12;
		end else begin
			case (cfg_d[GRAY_W_LO +: 2])
				2'h2:    gray_counter_bits_out <= GRAY_BITS_10;
				2'h3:    gray_counter_bits_out <= GRAY_BITS_8;
				default: gray_counter_bits_out <= GRAY_BITS_12;
			endcase
		end
	end

	// group brightness
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			b_group_brightness_out <= 8'h00;
			r_group_brightness_out <= 8'h00;
		end else begin
			b_group_brightness_out <= cfg_d[B_BRIGHT_LO +: 8];
			r_group_brightness_out <= cfg_d[R_BRIGHT_LO +: 8];
		end
	end

	// per-channel dot correction, r n at 21n, b n at 21n+14
	for (genvar ch = 0; ch < CH_N; ch++) begin : g_dc
		localparam int POS = (ch < 8) ? ch * DC_STEP : (ch - 8) * DC_STEP + DC_B_SHIFT;
		always_ff @(posedge clk_in) begin
			if (!rst_n_in) begin
				channel_dot_correction_out[ch*DC_W +: DC_W] <= 7'h00;
			end else begin
				channel_dot_correction_out[ch*DC_W +: DC_W] <= cfg_d[POS +: DC_W];
			end
		end
	end

	// ==========================================================
	// sticky fault flags, a new event wins over a clear
	logic [CH_N-1:0] open1_q, open2_q, short1_q, short2_q, neigh_q;
	logic [7:0]      unused_q;
	logic            overtemp_q, prewarn_q, ref_short_q, ref_open_q;
	logic [2:0]      ntest_q, self_q;
	logic            negate_bit_one_q, negate_bit_zero_q;

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			open1_q  <= '0;
			open2_q  <= '0;
			short1_q <= '0;
			short2_q <= '0;
			neigh_q  <= '0;
			unused_q <= 8'h00;
		end else begin
			open1_q  <= (do_clear ? '0 : open1_q) | open_first_in;
			open2_q  <= (do_clear ? '0 : open2_q) | open_second_in;
			short1_q <= (do_clear ? '0 : short1_q) | short_first_in;
			short2_q <= (do_clear ? '0 : short2_q) | short_second_in;
			neigh_q  <= (do_clear ? '0 : neigh_q) | neighbour_short_in;
			unused_q <= (do_clear ? 8'h00 : unused_q) | unused_pin_neighbour_in;
		end
	end

	// device-level fault flags
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			overtemp_q  <= 1'b0;
			prewarn_q   <= 1'b0;
			ref_short_q <= 1'b0;
			ref_open_q  <= 1'b0;
		end else begin
			overtemp_q  <= (overtemp_q && !do_clear) || overtemp_in;
			prewarn_q   <= (prewarn_q && !do_clear) || prewarn_in;
			ref_short_q <= (ref_short_q && !do_clear) || ref_short_in;
			ref_open_q  <= (ref_open_q && !do_clear) || ref_open_in;
		end
	end

	// test results, a finishing test overrides a clear
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			ntest_q <= RESULT_NONE;
			self_q  <= RESULT_NONE;
		end else begin
			if (neighbour_test_done_in) begin
				ntest_q <= neighbour_test_pass_in ? RESULT_PASS : RESULT_FAIL;
			end else if (do_clear) begin
				ntest_q <= RESULT_NONE;
			end
			if (selftest_done_in) begin
				self_q <= selftest_pass_in ? RESULT_PASS : RESULT_FAIL;
			end else if (do_clear) begin
				self_q <= RESULT_NONE;
			end
		end
	end

	// negate bits follow the toggling logic
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			negate_bit_one_q <= 1'b0;
			negate_bit_zero_q <= 1'b0;
		end else begin
			negate_bit_one_q <= negate_bit_one_in;
			negate_bit_zero_q <= negate_bit_zero_in;
		end
	end

	// ==========================================================
	// status image, reserved bits zero
	logic [WORD_W-1:0] status_img;

	always_comb begin
		status_img                       = '0;
		status_img[ST_OPEN2_B +: 8]      = open2_q[15:8];
		status_img[ST_OPEN2_R +: 8]      = open2_q[7:0];
		status_img[ST_OPEN1_B +: 8]      = open1_q[15:8];
		status_img[ST_OPEN1_R +: 8]      = open1_q[7:0];
		status_img[ST_NEIGH_B +: 8]      = neigh_q[15:8];
		status_img[ST_UNUSED +: 8]       = unused_q;
		status_img[ST_NEIGH_R +: 8]      = neigh_q[7:0];
		status_img[ST_OVERTEMP]          = overtemp_q;
		status_img[ST_PREWARN]           = prewarn_q;
		status_img[ST_NTEST_LO +: 3]     = ntest_q;
		status_img[ST_REF_SHORT]         = ref_short_q;
		status_img[ST_REF_OPEN]          = ref_open_q;
		status_img[ST_SELF_LO +: 3]      = self_q;
		status_img[ST_NEGATE_BIT_ONE]              = negate_bit_one_q;
		status_img[ST_NEGATE_BIT_ZERO]              = negate_bit_zero_q;
		status_img[ST_SHORT2_B +: 8]     = short2_q[15:8];
		status_img[ST_SHORT2_R +: 8]     = short2_q[7:0];
		status_img[ST_SHORT1_B +: 8]     = short1_q[15:8];
		status_img[ST_SHORT1_R +: 8]     = short1_q[7:0];
	end

	// ==========================================================
	// read-back, word and source hold until the next status or config read command, valid for one cycle
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			read_valid_out  <= 1'b0;
			read_source_out <= 2'h0;
			read_word_out   <= '0;
		end else begin
			read_valid_out <= do_status_read || do_config_read;
			if (do_status_read) begin
				read_source_out <= OFS_STATUS;
				read_word_out   <= status_img;
			end else if (do_config_read) begin
				read_source_out <= OFS_CONFIG;
				read_word_out   <= {{(WORD_W-CFG_W){1'b0}}, cfg_q};
			end
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	a_slew_edge_time: assert property (slew_slow_out |-> edge_cycles_out == 5'd20)
		else $error("slow slew not 200 ns");
	a_store_threshold: assert property (do_store |=> open_threshold_select_out == $past(frame_word_in[202])
		&& short_threshold_select_out == $past(frame_word_in[201]))
		else $error("threshold selects not loaded");
	a_test_duration: assert property (
		neighbour_test_cycles_out == (cfg_q[NTEST_DUR_BIT] ? 11'd2000 : 11'd1000))
		else $error("neighbour test duration wrong");
	a_gray_width: assert property (cfg_q[198:197] == 2'h3 |-> gray_counter_bits_out == 4'h8)
		else $error("eight-bit width not decoded");
	a_brightness_load: assert property (do_store |=> b_group_brightness_out == $past(frame_word_in[191:184]))
		else $error("b brightness not loaded");
	a_dot_r0_load: assert property (do_store |=> channel_dot_correction_out[6:0] == $past(frame_word_in[6:0]))
		else $error("r0 dot correction not loaded");
	a_event_beats_clear: assert property (do_clear && overtemp_in |=> overtemp_q)
		else $error("event lost during clear");
	a_clear_flags: assert property (do_clear && !ref_open_in |=> !ref_open_q)
		else $error("error clear failed");
	a_ntest_result: assert property (neighbour_test_done_in && !neighbour_test_pass_in |=> ntest_q == 3'h6
		##1 (ntest_q == 3'h6 || $past(neighbour_test_done_in) || $past(do_clear)))
		else $error("neighbour fail result wrong");
	a_status_read: assert property (do_status_read |=> read_valid_out && read_word_out[215] == $past(overtemp_q)
		##1 !read_valid_out || $past(frame_valid_in))
		else $error("status read not answered");

	c_status_read: cover property (do_status_read ##1 read_valid_out);
	c_error_clear: cover property (overtemp_q ##1 do_clear ##1 !overtemp_q);
	c_config_store: cover property (do_store ##1 slew_slow_out);
	c_selftest_pass: cover property (selftest_done_in && selftest_pass_in ##1 self_q == 3'h3);

endmodule : lcsr_regs

// [lcsr_host_model.sv]
// lcsr_host_model: host side of the frame interface of the register bank.
// assumes frames are taken on the rising edge, so it drives on the falling one.
`timescale 1ns/1ns

module lcsr_host_model (
	// clock
	input  wire logic                        clk_in,
	// frame toward the register bank
	output logic                             frame_valid_out,
	output logic [lcsr_pkg::WORD_W-1:0]      frame_word_out
);
	import lcsr_pkg::*;

	// ==========================================================
	// idle bus
	initial begin
		frame_valid_out = 1'h0;
		frame_word_out  = '0;
	end

	// ==========================================================
	// one frame: command on top, reserved bits zero, config below
	task automatic send(input logic [11:0] cmd, input logic [CFG_W-1:0] cfg);
		@(negedge clk_in);
		frame_valid_out = 1'h1;
		frame_word_out  = {cmd, 71'h0, cfg};
		@(negedge clk_in);
		frame_valid_out = 1'h0;
		frame_word_out  = ~frame_word_out; // released word must not linger
	endtask : send
endmodule : lcsr_host_model

// [tb_top.sv]
// tb_top: self-checking bench for the led driver register bank.
// assumes the host model drives frames and this bench drives detector events.
`timescale 1ns/1ns

module tb_top;
	import lcsr_pkg::*;

	// ==========================================================
	// signals
	logic clk_in = 1'h0, rst_n_in = 1'h0, frame_valid_in, read_valid_out;
	logic [WORD_W-1:0] frame_word_in, read_word_out;
	logic [1:0] read_source_out;
	logic led_error_mask_out, slew_slow_out, open_threshold_select_out, short_threshold_select_out;
	logic neighbour_test_current_out, timing_reset_en_out, auto_repeat_en_out;
	logic b_group_correction_range_out, r_group_correction_range_out;
	logic [4:0] edge_cycles_out;
	logic [10:0] neighbour_test_cycles_out;
	logic [3:0] gray_counter_bits_out;
	logic [7:0] b_group_brightness_out, r_group_brightness_out, unused_pin_neighbour_in = 8'h0;
	logic [CH_N*7-1:0] channel_dot_correction_out;
	logic [15:0] open_first_in = 16'h0, open_second_in = 16'h0, short_first_in = 16'h0;
	logic [15:0] short_second_in = 16'h0, neighbour_short_in = 16'h0;
	logic overtemp_in = 1'h0, prewarn_in = 1'h0, ref_short_in = 1'h0, ref_open_in = 1'h0;
	logic neighbour_test_done_in = 1'h0, neighbour_test_pass_in = 1'h0, selftest_done_in = 1'h0;
	logic selftest_pass_in = 1'h0, negate_bit_one_in = 1'h0, negate_bit_zero_in = 1'h0;
	int n_mismatch = 0, checks_done = 0;

	// ==========================================================
	// clock, design and host
	always #5 clk_in = ~clk_in;
	lcsr_regs u_lcsr_regs (.clk_in, .rst_n_in, .frame_valid_in, .frame_word_in, .read_valid_out,
		.read_source_out, .read_word_out, .led_error_mask_out, .slew_slow_out, .edge_cycles_out,
		.open_threshold_select_out, .short_threshold_select_out, .neighbour_test_current_out,
		.neighbour_test_cycles_out, .gray_counter_bits_out, .timing_reset_en_out, .auto_repeat_en_out,
		.b_group_correction_range_out, .r_group_correction_range_out, .b_group_brightness_out,
		.r_group_brightness_out, .channel_dot_correction_out, .open_first_in, .open_second_in,
		.short_first_in, .short_second_in, .neighbour_short_in, .unused_pin_neighbour_in, .overtemp_in,
		.prewarn_in, .ref_short_in, .ref_open_in, .neighbour_test_done_in, .neighbour_test_pass_in,
		.selftest_done_in, .selftest_pass_in, .negate_bit_one_in, .negate_bit_zero_in);
	lcsr_host_model u_lcsr_host_model (.clk_in(clk_in), .frame_valid_out(frame_valid_in),
		.frame_word_out(frame_word_in));

	// ==========================================================
	// compare, read and closing tasks
	task automatic check(input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check

	task automatic rd(input logic [11:0] cmd, input logic [1:0] src, input logic [WORD_W-1:0] exp);
		u_lcsr_host_model.send(cmd, '0);
		check(read_valid_out, 1'h1);
		check(read_source_out, src);
		check(read_word_out, exp);
	endtask : rd

	task automatic finish_test;
		$display("checks_done=%0d n_mismatch=%0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : finish_test

	// watchdog well beyond the roughly thirty cycles of the tests
	initial begin
		#20000;
		n_mismatch++;
		finish_test();
	end

	// ==========================================================
	// test sequence
	initial begin
		logic [CFG_W-1:0] cfg;
		logic [WORD_W-1:0] exp;
		repeat (2) @(negedge clk_in);
		rst_n_in = 1'h1;
		check(led_error_mask_out, 1'h1);
		check(edge_cycles_out, 5'h0A);
		check(neighbour_test_cycles_out, 11'h3E8);
		check(gray_counter_bits_out, GRAY_BITS_12);
		rd(CMD_STATUS_READ, OFS_STATUS, '0);
		// every width code, with the single-bit fields but the error mask toggled alongside
		for (int i = 0; i < 4; i++) begin
			cfg = '0;
			{cfg[SLEW_BIT], cfg[OPEN_THR_BIT], cfg[NTEST_CUR_BIT], cfg[AUTO_REP_BIT]} = {4{i[0]}};
			{cfg[NTEST_DUR_BIT], cfg[SHORT_THR_BIT], cfg[TIMING_RST_BIT]} = {3{i[1]}};
			{cfg[B_RANGE_BIT], cfg[R_RANGE_BIT]} = {i[0], i[1]};
			cfg[198:197] = i[1:0];
			cfg[191:184] = 8'hA5 ^ i[7:0];
			cfg[175:168] = 8'h3C + i[7:0];
			{cfg[167:161], cfg[20:14], cfg[6:0]} = {7'h40 + i[6:0], 7'h11 * i[6:0], 7'h7F - i[6:0]};
			u_lcsr_host_model.send(12'h000, cfg);
			check(slew_slow_out, i[0]);
			check(edge_cycles_out, i[0] ? 5'h14 : 5'h0A);
			check(open_threshold_select_out, i[0]);
			check(short_threshold_select_out, i[1]);
			check(neighbour_test_current_out, i[0]);
			check(neighbour_test_cycles_out, i[1] ? 11'h7D0 : 11'h3E8);
			check(gray_counter_bits_out, i < 2 ? GRAY_BITS_12 : i == 2 ? GRAY_BITS_10 : GRAY_BITS_8);
			check({timing_reset_en_out, auto_repeat_en_out}, {i[1], i[0]});
			check({b_group_correction_range_out, r_group_correction_range_out}, {i[0], i[1]});
			check({b_group_brightness_out, r_group_brightness_out}, {cfg[191:184], cfg[175:168]});
			check({channel_dot_correction_out[111:105], channel_dot_correction_out[62:56],
				channel_dot_correction_out[6:0]}, {cfg[167:161], cfg[20:14], cfg[6:0]});
			rd(CMD_CONFIG_READ, OFS_CONFIG, {83'h0, cfg});
			check(gray_counter_bits_out, i < 2 ? GRAY_BITS_12 : i == 2 ? GRAY_BITS_10 : GRAY_BITS_8);
		end
		// one pulse of every detector event but the negate bits, negate bit one raised and held
		@(negedge clk_in);
		{open_first_in, open_second_in, short_first_in} = {16'h0100, 16'h8001, 16'h0001};
		{short_second_in, neighbour_short_in, unused_pin_neighbour_in} = {16'h0100, 16'h0081, 8'h80};
		{overtemp_in, prewarn_in, ref_short_in, ref_open_in} = 4'hF;
		{neighbour_test_done_in, neighbour_test_pass_in, selftest_done_in, selftest_pass_in} = 4'hE;
		negate_bit_one_in = 1'h1;
		@(negedge clk_in);
		{open_first_in, open_second_in, short_first_in, short_second_in, neighbour_short_in} = '0;
		{unused_pin_neighbour_in, overtemp_in, prewarn_in, ref_short_in, ref_open_in} = '0;
		{neighbour_test_done_in, neighbour_test_pass_in, selftest_done_in, selftest_pass_in} = 4'h0;
		exp = '0;
		{exp[287], exp[264], exp[256]} = 3'h7;
		{exp[184], exp[144]} = 2'h3;
		{exp[223], exp[216], exp[231]} = 3'h7;
		exp[215:204] = {2'h3, RESULT_PASS, 2'h3, RESULT_FAIL, 2'h2};
		rd(CMD_STATUS_READ, OFS_STATUS, exp);
		// error clear keeps the negate copy, then opposite test outcomes
		u_lcsr_host_model.send(CMD_ERROR_CLEAR, '0);
		exp = '0;
		exp[205] = 1'h1;
		rd(CMD_STATUS_READ, OFS_STATUS, exp);
		@(negedge clk_in);
		{neighbour_test_done_in, neighbour_test_pass_in, selftest_done_in, selftest_pass_in} = 4'hB;
		@(negedge clk_in);
		{neighbour_test_done_in, selftest_done_in} = 2'h0;
		{exp[213:211], exp[208:206]} = {RESULT_FAIL, RESULT_PASS};
		rd(CMD_STATUS_READ, OFS_STATUS, exp);
		finish_test();
	end
endmodule : tb_top
